//--- logic/cci_target_pkg.sv
// Constants and types shared by the two-wire register access target.
package cci_target_pkg;
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h10; // Arbitrary neutral bus address.
  localparam int BYTE_BITS = 8;
  localparam int REG_ADDR_BITS = 16;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [7:0] UNREADABLE_VALUE = 8'h00;
  localparam logic [15:0] INDEX_RESET = 16'h0000;
  // SCL rate ceilings in kHz for the two reference clock ranges.
  localparam int SCL_FAST_PLUS_KHZ = 1000;
  localparam int SCL_FAST_KHZ = 400;
  // Byte phase of a transfer; Gray coded along address, index high, index low, data.
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_DEVADDR = 3'b001,
    PH_IDX_HI = 3'b011,
    PH_IDX_LO = 3'b010,
    PH_WDATA = 3'b110,
    PH_RDATA = 3'b111,
    PH_IGNORE = 3'b101
  } phase_t;
endpackage : cci_target_pkg

//--- logic/cci_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for one pin with a registered edge history.
module cci_pin_sync (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  output logic level_o,
  output logic prev_o
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Reset high matches an idle open-drain bus; stage two and the history stage feed logic, stage one never does.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign prev_o = prev_reg;
endmodule : cci_pin_sync
`default_nettype wire

//--- logic/cci_register_access_target.sv
`timescale 1ns/1ps
`default_nettype none
// Target side of the two-wire camera control link with an auto-incrementing index.
// Summary of operation
// - Six transactions: random/current reads, random writes.
// - Index register addresses every read and write.
// - Repeated start keeps the loaded index.
// - Read address: acknowledge, then drive byte at index.
// - Written register address loads index, survives stop.
// - Index increments at each data byte's ack/nack.
// - Read without dummy write returns data at index.
// - Controller ack advances read; nack plus stop ends.
// - Single write stores one byte at index.
// - Write data acknowledged and index incremented together.
// - 16-bit index, 8-bit data, MSB first, ack.
// - Direction bit 0 writes, 1 reads.
// - Unreadable registers read as 00h.
module cci_register_access_target #(
  parameter logic [6:0] TARGET_ADDR = cci_target_pkg::TARGET_ADDR_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [15:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_readable_i,
  output logic busy_o
);
  logic scl_s;
  logic scl_p;
  logic sda_s;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  cci_pin_sync u_scl_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(scl_i),
    .level_o(scl_s),
    .prev_o(scl_p)
  );
  cci_pin_sync u_sda_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pin_i(sda_i),
    .level_o(sda_s),
    .prev_o(sda_p)
  );

  // Line events; SDA moving while SCL stays high marks start and stop.
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

  cci_target_pkg::phase_t phase_reg, phase_next;
  logic [2:0] bit_reg, bit_next;
  logic ack_slot_reg, ack_slot_next;
  logic [7:0] shift_reg, shift_next;
  logic [15:0] index_reg, index_next;
  logic [7:0] hi_reg, hi_next;
  logic [7:0] tx_reg, tx_next;
  logic drive_reg, drive_next;
  logic out_bit_reg, out_bit_next;
  logic wr_reg, wr_next;
  logic rd_reg, rd_next;
  logic [7:0] wdata_reg, wdata_next;
  logic mack_reg, mack_next;
  logic last_reg, last_next;
  logic [7:0] rx_byte;
  logic [7:0] read_value;

  // Byte as it stands after the eighth sample.
  assign rx_byte = {shift_reg[6:0], sda_s};
  assign read_value = reg_readable_i ? reg_rdata_i : cci_target_pkg::UNREADABLE_VALUE;

  // Next-state logic for the byte engine. Bits are sampled on SCL rise and the
  // line is changed only on SCL fall, which keeps SDA stable while SCL is high.
  always_comb begin
    phase_next = phase_reg;
    bit_next = bit_reg;
    ack_slot_next = ack_slot_reg;
    shift_next = shift_reg;
    index_next = index_reg;
    hi_next = hi_reg;
    tx_next = tx_reg;
    drive_next = drive_reg;
    out_bit_next = out_bit_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    wdata_next = wdata_reg;
    mack_next = mack_reg;
    last_next = last_reg;
    if (start_det) begin
      // A repeated start leaves the index alone so a dummy write sticks.
      phase_next = cci_target_pkg::PH_DEVADDR;
      bit_next = cci_target_pkg::BIT_MSB;
      ack_slot_next = 1'b0;
      last_next = 1'b0;
      drive_next = 1'b0;
    end else if (stop_det) begin
      phase_next = cci_target_pkg::PH_IDLE;
      drive_next = 1'b0;
    end else if (phase_reg != cci_target_pkg::PH_IDLE
                 && phase_reg != cci_target_pkg::PH_IGNORE) begin
      if (scl_rise) begin
        if (!ack_slot_reg) begin
          shift_next = rx_byte;
          if (bit_reg != 3'h0) begin
            bit_next = bit_reg - 3'h1;
          end else begin
            // Eighth sample taken; the count alone would open the slot a bit early.
            last_next = 1'b1;
          end
        end else if (phase_reg == cci_target_pkg::PH_RDATA) begin
          mack_next = ~sda_s;
          index_next = index_reg + 16'h0001;
        end
      end else if (scl_fall) begin
        if (!ack_slot_reg && last_reg) begin
          // Eighth bit done: decide whether this target answers the byte.
          ack_slot_next = 1'b1;
          last_next = 1'b0;
          unique case (phase_reg)
            cci_target_pkg::PH_DEVADDR: begin
              if (shift_reg[7:1] == TARGET_ADDR) begin
                drive_next = 1'b1;
                out_bit_next = 1'b0;
              end else begin
                phase_next = cci_target_pkg::PH_IGNORE;
                drive_next = 1'b0;
              end
            end
            cci_target_pkg::PH_IDX_HI: begin
              hi_next = shift_reg;
              drive_next = 1'b1;
              out_bit_next = 1'b0;
            end
            cci_target_pkg::PH_IDX_LO: begin
              index_next = {hi_reg, shift_reg};
              drive_next = 1'b1;
              out_bit_next = 1'b0;
            end
            cci_target_pkg::PH_WDATA: begin
              // Store at the index and advance it in the same acknowledge.
              wdata_next = shift_reg;
              wr_next = 1'b1;
              index_next = index_reg + 16'h0001;
              drive_next = 1'b1;
              out_bit_next = 1'b0;
            end
            cci_target_pkg::PH_RDATA: begin
              drive_next = 1'b0;
            end
            default: begin
              drive_next = 1'b0;
            end
          endcase
        end else if (!ack_slot_reg) begin
          if (phase_reg == cci_target_pkg::PH_RDATA) begin
            out_bit_next = tx_reg[bit_reg];
          end
        end else begin
          // Leaving the acknowledge slot into the next byte.
          ack_slot_next = 1'b0;
          bit_next = cci_target_pkg::BIT_MSB;
          unique case (phase_reg)
            cci_target_pkg::PH_DEVADDR: begin
              if (shift_reg[0] == cci_target_pkg::DIR_READ) begin
                phase_next = cci_target_pkg::PH_RDATA;
                tx_next = read_value;
                rd_next = 1'b1;
                drive_next = 1'b1;
                out_bit_next = read_value[7];
              end else begin
                phase_next = cci_target_pkg::PH_IDX_HI;
                drive_next = 1'b0;
              end
            end
            cci_target_pkg::PH_IDX_HI: begin
              phase_next = cci_target_pkg::PH_IDX_LO;
              drive_next = 1'b0;
            end
            cci_target_pkg::PH_IDX_LO: begin
              phase_next = cci_target_pkg::PH_WDATA;
              drive_next = 1'b0;
            end
            cci_target_pkg::PH_WDATA: begin
              drive_next = 1'b0;
            end
            cci_target_pkg::PH_RDATA: begin
              if (mack_reg) begin
                tx_next = read_value;
                rd_next = 1'b1;
                drive_next = 1'b1;
                out_bit_next = read_value[7];
              end else begin
                // Controller refused the byte; release and wait for stop.
                phase_next = cci_target_pkg::PH_IGNORE;
                drive_next = 1'b0;
              end
            end
            default: begin
              drive_next = 1'b0;
            end
          endcase
        end
      end
    end
  end

  // Registers of the byte engine.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_reg <= cci_target_pkg::PH_IDLE;
      bit_reg <= cci_target_pkg::BIT_MSB;
      ack_slot_reg <= 1'b0;
      shift_reg <= 8'h00;
      index_reg <= cci_target_pkg::INDEX_RESET;
      hi_reg <= 8'h00;
      tx_reg <= 8'h00;
      drive_reg <= 1'b0;
      out_bit_reg <= 1'b1;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      wdata_reg <= 8'h00;
      mack_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      ack_slot_reg <= ack_slot_next;
      shift_reg <= shift_next;
      index_reg <= index_next;
      hi_reg <= hi_next;
      tx_reg <= tx_next;
      drive_reg <= drive_next;
      out_bit_reg <= out_bit_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      wdata_reg <= wdata_next;
      mack_reg <= mack_next;
      last_reg <= last_next;
    end
  end

  // Open drain: a one is sent by releasing the line, never by driving it high.
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_reg & ~out_bit_reg;
  // The write pulse sees the post-increment index, so it is held one cycle back.
  logic [15:0] wr_addr_reg;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_addr_reg <= cci_target_pkg::INDEX_RESET;
    end else begin
      wr_addr_reg <= index_reg;
    end
  end
  assign reg_addr_o = wr_reg ? wr_addr_reg : index_reg;
  assign reg_wdata_o = wdata_reg;
  assign reg_wr_o = wr_reg;
  assign reg_rd_o = rd_reg;
  assign busy_o = (phase_reg != cci_target_pkg::PH_IDLE);

  // Checks on the engine.
  property p_index_on_wdata;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      reg_wr_o |-> (index_reg == reg_addr_o + 16'h0001);
  endproperty
  a_index_on_wdata: assert property (p_index_on_wdata) else $error("Index not advanced on write.");

  property p_start_keeps_index;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      start_det |=> $stable(index_reg);
  endproperty
  a_start_keeps_index: assert property (p_start_keeps_index) else $error("Start changed index.");

  property p_stop_keeps_index;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      stop_det |=> $stable(index_reg) ##1 $stable(index_reg);
  endproperty
  a_stop_keeps_index: assert property (p_stop_keeps_index) else $error("Stop changed index.");

  property p_read_inc;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (scl_rise && ack_slot_reg && phase_reg == cci_target_pkg::PH_RDATA)
        |=> (index_reg == $past(index_reg) + 16'h0001);
  endproperty
  a_read_inc: assert property (p_read_inc) else $error("Read did not advance index.");

  property p_unreadable;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_o && !$past(reg_readable_i)) |-> (tx_reg == 8'h00);
  endproperty
  a_unreadable: assert property (p_unreadable) else $error("Unreadable byte not zero.");

  property p_ignore_released;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (phase_reg == cci_target_pkg::PH_IGNORE) |-> !sda_oe_o;
  endproperty
  a_ignore_released: assert property (p_ignore_released) else $error("Drove SDA when ignoring.");

  property p_no_drive_idle;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (phase_reg == cci_target_pkg::PH_IDLE) |-> !sda_oe_o;
  endproperty
  a_no_drive_idle: assert property (p_no_drive_idle) else $error("Drove SDA while idle.");

  property p_read_first_bit;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      reg_rd_o |-> (sda_oe_o == ~tx_reg[7]);
  endproperty
  a_read_first_bit: assert property (p_read_first_bit) else $error("Read byte not MSB first.");

  property p_read_dir;
    @(posedge sys_clk_i) disable iff (!rst_b_i)
      (reg_rd_o && $past(phase_reg) == cci_target_pkg::PH_DEVADDR) |-> $past(shift_reg[0]);
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("Read started on write bit.");
endmodule : cci_register_access_target
`default_nettype wire

//--- bench/cci_bus_controller.sv
// Behavioural two-wire bus controller that drives the target's link.
`timescale 1ns/1ps
`default_nettype none
module cci_bus_controller (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  // SCL idles high and only toggles inside frames; SDA is released.
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // A quarter of an SCL period, so every link edge lands just after a clock edge.
  // The 400 ns link period outruns the rate ceilings to keep runs short; the target
  // itself needs only four system clocks per SCL half period.
  task automatic q();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : q
  // Start, or repeated start when no stop came first; the index is kept.
  task automatic start();
    sda_pull_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_pull_o = 1'b1;
    q();
    scl_o = 1'b0;
    q();
  endtask : start
  // Sends d MSB first, then ack_in in the ninth slot; a one leaves SDA released.
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                      output logic ack);
    logic [8:0] bits;
    bits = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_pull_o = ~bits[i];
      q();
      scl_o = 1'b1;
      q();
      if (i > 0) begin
        r[i-1] = sda_i;
      end else begin
        ack = sda_i;
      end
      q();
      scl_o = 1'b0;
      q();
    end
  endtask : xfer
  // Stop closes every frame, also straight after a refused or final byte.
  task automatic stop();
    sda_pull_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_pull_o = 1'b0;
    q();
  endtask : stop
endmodule : cci_bus_controller
`default_nettype wire

//--- bench/test_cci_register_access_target.sv
// Self-checking bench for the two-wire register access target.
`timescale 1ns/1ps
`default_nettype none
module test_cci_register_access_target;
  localparam logic [6:0] ADDR = cci_target_pkg::TARGET_ADDR_DEFAULT;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic scl, ctl_pull, sda_oe, sda_out, sda;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, readable, busy;
  logic [7:0] regs [65536];
  logic [7:0] shadow [65536];
  int n_fail = 0;
  int n_tests = 0;
  int n_rd = 0;
  always #25 sys_clk = ~sys_clk;
  // Count register fetches so each read byte can be matched to one pulse.
  always @(posedge sys_clk) begin
    if (reg_rd) begin
      n_rd <= n_rd + 1;
    end
  end
  // Pulled-up open-drain wire: low whenever either party pulls it.
  assign sda = ~(ctl_pull | (sda_oe & ~sda_out));
  // Register file behind the target; the 2xxxh area stands in for unreadable ones.
  assign reg_rdata = regs[reg_addr];
  assign readable = reg_addr[15:12] != 4'h2;
  always @(posedge sys_clk) begin
    if (reg_wr) begin
      regs[reg_addr] <= reg_wdata;
    end
  end
  cci_register_access_target i_cci_register_access_target (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
    .reg_rdata_i(reg_rdata), .reg_readable_i(readable), .busy_o(busy));
  cci_bus_controller i_cci_bus_controller (
    .sys_clk_i(sys_clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(ctl_pull));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [7:0] expv(input logic [15:0] a);
    return (a[15:12] == 4'h2) ? 8'h00 : shadow[a];
  endfunction : expv
  // One controller byte that the target must acknowledge.
  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic a;
    i_cci_bus_controller.xfer(d, 1'b1, r, a);
    check("ack", 16'h0000, {15'h0000, a});
  endtask : send
  task automatic hdr(input logic dir);
    i_cci_bus_controller.start();
    send({ADDR, dir});
    check("busy", 16'h0001, {15'h0000, busy});
  endtask : hdr
  // Dummy write that only loads the index, upper byte first.
  task automatic set_index(input logic [15:0] idx);
    hdr(cci_target_pkg::DIR_WRITE);
    send(idx[15:8]);
    send(idx[7:0]);
  endtask : set_index
  // Stop, then let the synchroniser settle before looking at busy.
  task automatic fin();
    i_cci_bus_controller.stop();
    repeat (4) @(posedge sys_clk);
    #1;
    check("idle", 16'h0000, {15'h0000, busy});
  endtask : fin
  task automatic t_write(input logic [15:0] idx, input int n, input logic [7:0] d0);
    set_index(idx);
    for (int i = 0; i < n; i++) begin
      send(d0 + 8'(i));
      shadow[idx + 16'(i)] = d0 + 8'(i);
    end
    fin();
    for (int i = 0; i < n; i++) begin
      check("stored", {8'h00, shadow[idx + 16'(i)]}, {8'h00, regs[idx + 16'(i)]});
    end
  endtask : t_write
  // Read n bytes, from a supplied index or from the held one.
  task automatic t_read(input logic random, input logic [15:0] idx, input int n);
    logic [7:0] r;
    logic a;
    int rd0;
    if (random) begin
      set_index(idx);
    end
    rd0 = n_rd;
    hdr(cci_target_pkg::DIR_READ);
    for (int i = 0; i < n; i++) begin
      i_cci_bus_controller.xfer(8'hFF, i == n - 1, r, a);
      check("read data", {8'h00, expv(idx + 16'(i))}, {8'h00, r});
    end
    fin();
    check("fetches", 16'(n), 16'(n_rd - rd0));
  endtask : t_read
  // Another bus address is left unanswered and the line stays released.
  task automatic t_foreign();
    logic [7:0] r;
    logic a;
    i_cci_bus_controller.start();
    i_cci_bus_controller.xfer({ADDR ^ 7'h01, 1'b1}, 1'b1, r, a);
    check("foreign ack", 16'h0001, {15'h0000, a});
    i_cci_bus_controller.xfer(8'hFF, 1'b1, r, a);
    check("foreign data", 16'h00FF, {8'h00, r});
    fin();
  endtask : t_foreign
  task automatic wrap_up();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    for (int i = 0; i < 65536; i++) begin
      regs[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
      shadow[i] = regs[i];
    end
    repeat (8) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    t_write(16'h12FE, 3, 8'hA0);
    t_read(1'b1, 16'h12FE, 3);
    t_read(1'b0, 16'h1301, 1);
    t_read(1'b0, 16'h1302, 2);
    t_foreign();
    t_read(1'b0, 16'h1304, 1);
    t_write(16'hFFFF, 1, 8'h5C);
    t_read(1'b1, 16'hFFFF, 1);
    t_read(1'b1, 16'h1FFF, 2);
    wrap_up();
  end
  // A hang is cut short here; the run needs far fewer cycles.
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end
endmodule : test_cci_register_access_target
`default_nettype wire
